// *** hw/apr_route.sv ***
/*
  Second alert pin routing: register, event gating, conversion pulse and
  multipurpose pin control. Event inputs come from logic on the same clock;
  the pin input is asynchronous and synchronised here.
*/
`timescale 1ns/1ps
module apr_route
  import apr_pkg::*;
(
  input wire logic clock, // 250 MHz core clock
  input wire logic reset_n, // Async reset, active low
  input wire logic clk_en, // Freezes all state when low
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [23:0] reg_wdata, // Register write data
  output logic [23:0] reg_rdata_ff, // Read data, one cycle after strobe
  input wire apr_limit_t limit_evt, // Limit comparator levels
  input wire apr_fill_t fill_evt, // Accumulator fill levels
  input wire apr_fill_sel_t fill_sel, // Fullness thresholds
  input wire logic conv_done, // One-cycle conversion end pulse
  input wire logic pin_alert_mode, // Pin selected as alert output
  input wire logic gpio_out, // General purpose output value
  input wire logic gpio_oe, // General purpose output enable
  input wire logic pin_in, // Pin level, asynchronous
  output logic pin_out_ff, // Pin drive value
  output logic pin_oe_ff, // Pin output enable
  output logic gpio_in_ff, // Synchronised pin level
  output logic slow_req_ff // Slow sampling request from the pin
);

  // ---------------------------------------------------------------
  // Fullness compare
  // ---------------------------------------------------------------
  function automatic logic fill_trip(input logic [3:0] top,
                                     input logic ovf,
                                     input logic [1:0] sel);
    logic trip;
    trip = ovf;
    unique case (sel)
      APR_FULL_100: trip = ovf;
      APR_FULL_15_16: trip = ovf | (&top);
      APR_FULL_7_8: trip = ovf | (&top[3:1]);
      APR_FULL_3_4: trip = ovf | (&top[3:2]);
    endcase
    return trip;
  endfunction

  logic [23:0] route_ff;
  logic [10:0] pulse_cnt_ff;
  logic sync1_ff;
  logic sync2_ff;
  logic [3:0] acc_trip;
  logic cnt_trip;
  logic routed_any;
  logic nxt_alert;

  // ---------------------------------------------------------------
  // Routing register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      route_ff <= APR_ROUTE_RESET;
    end else if (clk_en && reg_wr && reg_addr == APR_ROUTE_ADDR) begin
      route_ff <= {reg_wdata[23:1], 1'b0};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= 24'h000000;
    end else if (clk_en && reg_rd) begin
      if (reg_addr == APR_ROUTE_ADDR) begin
        reg_rdata_ff <= {route_ff[23:1], 1'b0};
      end else begin
        reg_rdata_ff <= 24'h000000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Event gating
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_acc
    assign acc_trip[i] = fill_trip(fill_evt.acc_top[i],
                                   fill_evt.accumulator_full_route[i],
                                   fill_sel.acc_sel[i]);
  end
  assign cnt_trip = fill_trip(fill_evt.cnt_top, fill_evt.cnt_ovf,
                              fill_sel.cnt_sel);

  always_comb begin
    routed_any = 1'b0;
    routed_any |= |(limit_evt.over_current & route_ff[23:20]);
    routed_any |= |(limit_evt.under_current & route_ff[19:16]);
    routed_any |= limit_evt.over_voltage[3] & route_ff[APR_OV1_BIT];
    routed_any |= |(limit_evt.over_voltage[2:0] & route_ff[14:12]);
    routed_any |= |(limit_evt.under_voltage & route_ff[11:8]);
    routed_any |= |(limit_evt.over_power & route_ff[7:4]);
    routed_any |= (|acc_trip) & route_ff[APR_ACC_BIT];
    routed_any |= cnt_trip & route_ff[APR_CNT_BIT];
  end

  // ---------------------------------------------------------------
  // Conversion pulse
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulse_cnt_ff <= 11'h000;
    end else if (clk_en) begin
      if (conv_done && route_ff[APR_CC_BIT]) begin
        pulse_cnt_ff <= APR_PULSE_LEN;
      end else if (pulse_cnt_ff != 11'h000) begin
        pulse_cnt_ff <= pulse_cnt_ff - 11'h001;
      end
    end
  end

  assign nxt_alert = routed_any | (pulse_cnt_ff != 11'h000);

  // ---------------------------------------------------------------
  // Pin control
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else if (clk_en) begin
      if (pin_alert_mode) begin
        pin_out_ff <= nxt_alert;
        pin_oe_ff <= 1'b1;
      end else begin
        pin_out_ff <= gpio_out;
        pin_oe_ff <= gpio_oe;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
    end else if (clk_en) begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gpio_in_ff <= 1'b0;
      slow_req_ff <= 1'b0;
    end else if (clk_en) begin
      gpio_in_ff <= sync2_ff;
      slow_req_ff <= sync2_ff & ~pin_alert_mode;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [10:0] chk_hi_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chk_hi_ff <= 11'h000;
    end else if (clk_en) begin
      // Restart on a level event or a retrigger, both may hold the pin
      if (routed_any || (conv_done && route_ff[APR_CC_BIT])) begin
        chk_hi_ff <= 11'h000;
      end else if (pin_out_ff && pin_alert_mode) begin
        chk_hi_ff <= chk_hi_ff + 11'h001;
      end else begin
        chk_hi_ff <= 11'h000;
      end
    end
  end

  ov_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pin_alert_mode && limit_evt.over_voltage[1]
    && route_ff[13] |=> pin_out_ff)
    else $error("routed channel 3 overvoltage did not raise pin");

  uv_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pin_alert_mode && limit_evt.under_voltage[3]
    && route_ff[11] |=> pin_out_ff)
    else $error("routed channel 1 undervoltage did not raise pin");

  op_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pin_alert_mode && limit_evt.over_power[0]
    && route_ff[4] |=> pin_out_ff)
    else $error("routed channel 4 overpower did not raise pin");

  acc_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pin_alert_mode && fill_evt.accumulator_full_route[2]
    && route_ff[APR_ACC_BIT] |=> pin_out_ff)
    else $error("accumulator overflow did not raise pin");

  cnt_route_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pin_alert_mode && fill_evt.cnt_ovf
    && route_ff[APR_CNT_BIT] |=> pin_out_ff)
    else $error("counter overflow did not raise pin");

  pulse_len_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && conv_done && route_ff[APR_CC_BIT]
    |=> pulse_cnt_ff == APR_PULSE_LEN)
    else $error("conversion pulse length wrong");

  pulse_end_a: assert property (@(posedge clock) disable iff (!reset_n)
    chk_hi_ff <= APR_PULSE_LEN + 11'h001)
    else $error("conversion pulse too long");

  gpio_mode_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && !pin_alert_mode |=> pin_out_ff == $past(gpio_out))
    else $error("alert drove pin in gpio mode");

  slow_off_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pin_alert_mode |=> !slow_req_ff)
    else $error("slow request seen in alert mode");

  bit0_zero_a: assert property (@(posedge clock) disable iff (!reset_n)
    !reg_rdata_ff[0] && !route_ff[0])
    else $error("unimplemented bit 0 nonzero");

  quiet_pin_a: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pin_alert_mode && !routed_any && pulse_cnt_ff == 11'h000
    |=> !pin_out_ff)
    else $error("pin raised with no routed event");

endmodule

// *** pkg/apr_pkg.sv ***
/*
  Constants and carrier types for the second alert pin routing block.
  Assumes a 250 MHz core clock and a register port from the serial decoder.
*/
package apr_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] APR_ROUTE_ADDR = 8'h28;
  localparam logic [23:0] APR_ROUTE_RESET = 24'h000000;
  localparam int APR_OC_LSB = 20;
  localparam int APR_UC_LSB = 16;
  localparam int APR_OV1_BIT = 15;
  localparam int APR_OV_LSB = 12;
  localparam int APR_UV_LSB = 8;
  localparam int APR_OP_LSB = 4;
  localparam int APR_ACC_BIT = 3;
  localparam int APR_CNT_BIT = 2;
  localparam int APR_CC_BIT = 1;

  // ---------------------------------------------------------------
  // Fullness thresholds
  // ---------------------------------------------------------------
  localparam logic [1:0] APR_FULL_100 = 2'h0;
  localparam logic [1:0] APR_FULL_15_16 = 2'h1;
  localparam logic [1:0] APR_FULL_7_8 = 2'h2;
  localparam logic [1:0] APR_FULL_3_4 = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int APR_CLK_MHZ = 250;
  localparam int APR_PULSE_NS = 5000;
  localparam int APR_PULSE_CYC = APR_PULSE_NS * APR_CLK_MHZ / 1000;
  localparam logic [10:0] APR_PULSE_LEN = 11'(APR_PULSE_CYC);

  // Index 3 of every 4-bit vector is channel 1, index 0 channel 4
  typedef struct packed {
    logic [3:0] over_current;
    logic [3:0] under_current;
    logic [3:0] over_voltage;
    logic [3:0] under_voltage;
    logic [3:0] over_power;
  } apr_limit_t;

  // Accumulator top four bits and overflow flags
  typedef struct packed {
    logic [3:0][3:0] acc_top;
    logic [3:0] accumulator_full_route;
    logic [3:0] cnt_top;
    logic cnt_ovf;
  } apr_fill_t;

  // Fullness selects taken from the neighbouring limits register
  typedef struct packed {
    logic [3:0][1:0] acc_sel;
    logic [1:0] cnt_sel;
  } apr_fill_sel_t;

endpackage

// *** tb/apr_host_model.sv ***
/*
  Host model watching the second alert pin.
  Assumes drive and enable from the routing block on the core clock.
*/
`timescale 1ns/1ps
module apr_host_model (
  input wire logic clock, // Core clock
  input wire logic pin_out, // Device pin drive
  input wire logic pin_oe, // Device pin enable
  input wire logic host_drv, // Host level while device releases
  output logic pin_level, // Resolved wire level
  output int high_len // Cycles of the last asserted run
);
  int run_cnt = 0;
  int last_len = 0;
  assign high_len = last_len;
  // ---------------------------------------------------------------
  // Wire and run length
  // ---------------------------------------------------------------
  assign pin_level = pin_oe ? pin_out : host_drv;
  always @(posedge clock) begin
    if (pin_oe && pin_out) begin
      run_cnt <= run_cnt + 1;
    end else begin
      if (run_cnt != 0) begin
        last_len <= run_cnt;
      end
      run_cnt <= 0;
    end
  end
endmodule

// *** tb/apr_route_tb.sv ***
/*
  Bench for the second alert pin routing block.
  Assumes the host model; events arrive ungated and the routing register gates them.
*/
`timescale 1ns/1ps
module apr_route_tb;
  import apr_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h000000;
  logic [23:0] reg_rdata_ff;
  apr_limit_t limit_evt = '0;
  apr_fill_t fill_evt = '0;
  apr_fill_sel_t fill_sel = '0;
  logic conv_done = 1'b0;
  logic pin_alert_mode = 1'b1;
  logic gpio_out = 1'b0;
  logic gpio_oe = 1'b0;
  logic host_drv = 1'b0;
  logic pin_level, pin_out_ff, pin_oe_ff, gpio_in_ff, slow_req_ff;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int high_len;
  apr_route dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .limit_evt(limit_evt), .fill_evt(fill_evt), .fill_sel(fill_sel),
    .conv_done(conv_done), .pin_alert_mode(pin_alert_mode),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_in(pin_level),
    .pin_out_ff(pin_out_ff), .pin_oe_ff(pin_oe_ff),
    .gpio_in_ff(gpio_in_ff), .slow_req_ff(slow_req_ff));
  apr_host_model host (.clock(clock), .pin_out(pin_out_ff),
    .pin_oe(pin_oe_ff), .host_drv(host_drv), .pin_level(pin_level),
    .high_len(high_len));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [23:0] exp,
                       input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [23:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [23:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 check("read data", exp, reg_rdata_ff);
  endtask
  task automatic pin_is(input logic exp);
    repeat (2) @(posedge clock);
    #1 check("pin level", {23'h0, exp}, {23'h0, pin_out_ff});
    @(posedge clock);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_regs();
    reg_read(APR_ROUTE_ADDR, APR_ROUTE_RESET);
    reg_write(APR_ROUTE_ADDR, 24'hFFFFFF);
    reg_read(APR_ROUTE_ADDR, 24'hFFFFFE);
    reg_write(8'h29, 24'h000000);
    reg_read(APR_ROUTE_ADDR, 24'hFFFFFE);
    reg_read(8'h29, 24'h000000);
    clk_en <= 1'b0;
    reg_write(APR_ROUTE_ADDR, 24'h000000);
    clk_en <= 1'b1;
    reg_read(APR_ROUTE_ADDR, 24'hFFFFFE);
  endtask
  task automatic test_limits();
    for (int i = 0; i < 20; i++) begin
      reg_write(APR_ROUTE_ADDR, 24'h000010 << i);
      limit_evt <= apr_limit_t'(20'h00001 << i);
      pin_is(1'b1);
      limit_evt <= ~apr_limit_t'(20'h00001 << i);
      pin_is(1'b0);
    end
    limit_evt <= '0;
  endtask
  task automatic test_fill();
    reg_write(APR_ROUTE_ADDR, 24'h000008);
    fill_sel.acc_sel[2] <= APR_FULL_15_16;
    fill_evt.acc_top[2] <= 4'hE;
    pin_is(1'b0);
    fill_evt.acc_top[2] <= 4'hF;
    pin_is(1'b1);
    fill_sel.acc_sel[2] <= APR_FULL_3_4;
    fill_evt.acc_top[2] <= 4'hC;
    pin_is(1'b1);
    fill_sel.acc_sel[2] <= APR_FULL_7_8;
    pin_is(1'b0);
    fill_sel.acc_sel[2] <= APR_FULL_100;
    fill_evt.acc_top[2] <= 4'hF;
    pin_is(1'b0);
    fill_evt.accumulator_full_route[2] <= 1'b1;
    pin_is(1'b1);
    reg_write(APR_ROUTE_ADDR, 24'h000004);
    pin_is(1'b0);
    fill_evt <= '{acc_top: '0, accumulator_full_route: 4'h0, cnt_top: 4'hF, cnt_ovf: 1'b0};
    fill_sel.cnt_sel <= APR_FULL_15_16;
    pin_is(1'b1);
    fill_evt <= '{acc_top: '0, accumulator_full_route: 4'h0, cnt_top: 4'h0, cnt_ovf: 1'b1};
    fill_sel.cnt_sel <= APR_FULL_100;
    pin_is(1'b1);
    fill_evt <= '0;
  endtask
  task automatic test_pulse(input logic [23:0] route, input logic on);
    reg_write(APR_ROUTE_ADDR, route);
    conv_done <= 1'b1;
    @(posedge clock);
    conv_done <= 1'b0;
    repeat (APR_PULSE_CYC / 2) @(posedge clock);
    #1 check("pulse mid", {23'h0, on}, {23'h0, pin_out_ff});
    repeat (APR_PULSE_CYC) @(posedge clock);
    #1 check("pulse length", 24'(APR_PULSE_CYC), 24'(high_len));
    check("pulse end", 24'h0, {23'h0, pin_out_ff});
  endtask
  task automatic test_gpio();
    reg_write(APR_ROUTE_ADDR, 24'h000080);
    limit_evt.over_power <= 4'h8;
    pin_alert_mode <= 1'b0;
    host_drv <= 1'b1;
    repeat (4) @(posedge clock);
    #1 check("gpio pin", 24'h0, {22'h0, pin_oe_ff, pin_out_ff});
    check("gpio in", 24'h3, {22'h0, slow_req_ff, gpio_in_ff});
    @(posedge clock);
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check("gpio drive", 24'h3, {22'h0, pin_oe_ff, pin_out_ff});
    @(posedge clock);
    gpio_out <= 1'b0;
    pin_alert_mode <= 1'b1;
    repeat (4) @(posedge clock);
    #1 check("alert pin", 24'h3, {22'h0, pin_oe_ff, pin_out_ff});
    check("slow off", 24'h0, {23'h0, slow_req_ff});
  endtask
  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    test_regs();
    test_limits();
    test_fill();
    test_pulse(24'h000002, 1'b1);
    test_pulse(24'h000000, 1'b0);
    test_gpio();
    final_report();
  end
endmodule
